// File: wdtu_pkg.sv
// Constants, field layout and state type of the watchdog timer unit.
// Assumes one core clock and an oscillator tick already synchronous to it.
package wdtu_pkg;

	// Control register placement and layout
	localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hAA;
	localparam logic [7:0] CTRL_POR_VALUE = 8'h07;
	localparam int RUN_BIT = 7;
	localparam int CLR_BIT = 6;
	localparam int TOF_BIT = 5;
	localparam int LPR_BIT = 4;
	localparam int RSTF_BIT = 3;
	localparam int PS_MSB = 2;
	localparam int PS_LSB = 0;
	localparam logic [2:0] PS_POR_VALUE = 3'h7;

	// Configuration byte layout and mode codes
	localparam int CFG_MODE_MSB = 7;
	localparam int CFG_MODE_LSB = 4;
	localparam logic [7:0] CONFIG_DEFAULT = 8'hFF;
	localparam logic [3:0] MODE_GP = 4'hF;
	localparam logic [3:0] MODE_RST_STOP = 4'h5;

	// Timing: intervals in periods of the low-speed oscillator, then the clock rates
	localparam int TIMEOUT_TICKS = 64;
	localparam int GRACE_TICKS = 512;
	localparam int LSO_FREQ_HZ = 10000;
	localparam int CORE_FREQ_HZ = 100000000;
	localparam int LSO_PERIOD_CYCLES = CORE_FREQ_HZ / LSO_FREQ_HZ;

	typedef enum logic [1:0] {
		GRACE_IDLE,
		GRACE_WAIT,
		GRACE_FIRE
	} wdtu_grace_t;

	// Last divider value for each prescale code
	function automatic logic [7:0] wdtu_ps_limit(input logic [2:0] sel);
		logic [7:0] lim;
		lim = 8'h00;
		unique case (sel)
			3'h0: lim = 8'h00;
			3'h1: lim = 8'h03;
			3'h2: lim = 8'h07;
			3'h3: lim = 8'h0F;
			3'h4: lim = 8'h1F;
			3'h5: lim = 8'h3F;
			3'h6: lim = 8'h7F;
			3'h7: lim = 8'hFF;
		endcase
		return lim;
	endfunction : wdtu_ps_limit

endpackage : wdtu_pkg

// File: wdtu_prescaler.sv
// Divider chain on the oscillator tick, one output tick per divisor.
// Assumes oscTick is a one-cycle pulse synchronous to core_clk.
module wdtu_prescaler
	import wdtu_pkg::*;
#(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic clear,
	input wire logic enable,
	input wire logic [2:0] sel,
	// Ticks
	input wire logic oscTick,
	output logic outTick
);

	logic [DIV_W-1:0] div;
	logic atLimit;

	assign atLimit = (div >= wdtu_ps_limit(sel));
	assign outTick = enable && oscTick && atLimit && !clear;

	always_ff @(posedge core_clk) begin
		if (sys_rst || clear) begin
			div <= '0;
		end else if (enable && oscTick) begin
			// Limit compare, not equality: a smaller code mid-count must not stall
			if (atLimit) begin
				div <= '0;
			end else begin
				div <= div + 1'b1;
			end
		end
	end

endmodule : wdtu_prescaler

// File: wdtu_grace_timer.sv
// Grace window after a time-out; fires once unless cancelled.
// Assumes oscTick is a one-cycle pulse synchronous to core_clk.
module wdtu_grace_timer
	import wdtu_pkg::*;
#(
	parameter int GRACE = GRACE_TICKS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control
	input wire logic arm,
	input wire logic cancel,
	input wire logic enable,
	input wire logic oscTick,
	// Result
	output logic fire
);

	localparam int CW = $clog2(GRACE);
	localparam logic [CW-1:0] LAST = CW'(GRACE - 1);

	wdtu_grace_t state;
	logic [CW-1:0] cnt;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= GRACE_IDLE;
			cnt <= '0;
			fire <= 1'b0;
		end else begin
			fire <= 1'b0;
			unique case (state)
				GRACE_IDLE: begin
					cnt <= '0;
					if (arm && !cancel) begin
						state <= GRACE_WAIT;
					end
				end
				GRACE_WAIT: begin
					if (cancel) begin
						state <= GRACE_IDLE;
					end else if (enable && oscTick) begin
						if (cnt == LAST) begin
							state <= GRACE_FIRE;
						end else begin
							cnt <= cnt + 1'b1;
						end
					end
				end
				GRACE_FIRE: begin
					fire <= 1'b1;
					state <= GRACE_IDLE;
				end
				default: begin
					state <= GRACE_IDLE;
				end
			endcase
		end
	end

endmodule : wdtu_grace_timer

// File: wdtu_watchdog_timer_unit.sv
// Watchdog timer unit: control register, mode logic and time-out counter.
// Assumes oscillator tick, power-mode levels and bus inputs are synchronous.
//
// How it works
// R1: Config all ones gives software general timer.
// R2: Config 0101: reset timer, halts when asleep.
// R3: Other configs: reset timer, runs when asleep.
// R4: Time-out is 64 ticks times prescale divisor.
// R5: Prescale codes map to 1,4,8..256 divisors.
// R6: Reset modes count from reset release alone.
// R7: Time-out sets flag; interrupt needs both enables.
// R8: Reset mode: 512 ticks grace, then reset.
// R9: Clear bit zeroes count, self-clears when done.
// R10: Watchdog reset sets flag; power-on clears it.
// R11: Control writes only inside timed-access window.
// R12: Reset modes ignore run and low-power bits.
// R13: General mode: run bit starts, stops counter.
// R14: General mode keeps counting after each time-out.
// R15: Hardware only sets flag; software clears it.
// R16: General mode: low-power bit selects sleep counting.
// R17: Time-out wakes device from Idle, Power-down.
// R18: Control resets per power-on, watchdog, other reset.
// R19: Prescale all ones on power-on, else kept.
// R20: Clear acts on oscillator tick, then releases.
module wdtu_watchdog_timer_unit
	import wdtu_pkg::*;
#(
	parameter int PS_W = 8,
	parameter int GRACE = GRACE_TICKS
) (
	// Clock and power-on reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Other reset sources of the device
	input wire logic otherRst,
	// Configuration byte from non-volatile storage
	input wire logic [7:0] configByte,
	// Low-speed oscillator tick, one cycle per period
	input wire logic lowSpeedTick,
	// Power management levels
	input wire logic idleMode,
	input wire logic powerDownMode,
	// Special-function register port
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic taOpen,
	output logic [7:0] sfrRdData,
	// Interrupt enables
	input wire logic wdIrqEnable,
	input wire logic globalIrqEnable,
	// Events out
	output logic irqRequest,
	output logic wakeUp,
	output logic systemReset
);

	localparam int CNT_W = $clog2(TIMEOUT_TICKS);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_TICKS - 1);

	// Mode and control state
	logic [3:0] wdModeCfg;
	logic wdRun;
	logic wdLowpowerRun;
	logic wdTimeoutFlag;
	logic wdResetFlag;
	logic wdCountClear;
	logic [2:0] wdPrescaleSel;
	logic [CNT_W-1:0] wdCount;

	// Derived terms
	logic chipRst;
	logic ctrlWrite;
	logic gpMode;
	logic stopWhenAsleep;
	logic asleep;
	logic counting;
	logic countClearNow;
	logic psTick;
	logic timeoutEvt;
	logic graceFire;
	logic [7:0] ctrlRead;

	// Every reset source; the watchdog's own reset is the registered output
	assign chipRst = sys_rst || otherRst || systemReset;

	assign ctrlWrite = sfrWrEn && taOpen && (sfrAddr == WATCHDOG_CONTROL_ADDR); // R11

	assign gpMode = (wdModeCfg == MODE_GP); // R1
	assign stopWhenAsleep = (wdModeCfg == MODE_RST_STOP); // R2
	assign asleep = idleMode || powerDownMode;

	// Reset modes start on their own and ignore run and low-power bits
	always_comb begin
		if (gpMode) begin
			counting = wdRun && (!asleep || wdLowpowerRun); // R13 R16
		end else if (stopWhenAsleep) begin
			counting = !asleep; // R2 R6 R12
		end else begin
			counting = 1'b1; // R3 R6 R12
		end
	end

	// Clear lands on an oscillator edge, as the count lives on that rate
	assign countClearNow = wdCountClear && lowSpeedTick; // R20

	assign timeoutEvt = psTick && (wdCount == CNT_LAST) && !countClearNow; // R4

	// Mode is taken from the configuration byte at each reset
	always_ff @(posedge core_clk) begin
		if (chipRst) begin
			wdModeCfg <= configByte[CFG_MODE_MSB:CFG_MODE_LSB];
		end
	end

	// Run and low-power bits: zero after every kind of reset
	always_ff @(posedge core_clk) begin
		if (chipRst) begin
			wdRun <= CTRL_POR_VALUE[RUN_BIT]; // R18
			wdLowpowerRun <= CTRL_POR_VALUE[LPR_BIT]; // R18
		end else if (ctrlWrite) begin
			wdRun <= sfrWrData[RUN_BIT];
			wdLowpowerRun <= sfrWrData[LPR_BIT];
		end
	end

	// Prescale select survives all resets but power-on
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wdPrescaleSel <= PS_POR_VALUE; // R19 R18
		end else if (ctrlWrite) begin
			wdPrescaleSel <= sfrWrData[PS_MSB:PS_LSB];
		end
	end

	// Reset flag: hardware set beats a software write in the same cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wdResetFlag <= CTRL_POR_VALUE[RSTF_BIT]; // R10
		end else if (systemReset) begin
			wdResetFlag <= 1'b1; // R10 R18
		end else if (otherRst) begin
			wdResetFlag <= wdResetFlag; // R18
		end else if (ctrlWrite) begin
			wdResetFlag <= sfrWrData[RSTF_BIT]; // R10
		end
	end

	// Time-out flag: never cleared by hardware outside reset
	always_ff @(posedge core_clk) begin
		if (chipRst) begin
			wdTimeoutFlag <= CTRL_POR_VALUE[TOF_BIT]; // R18
		end else if (timeoutEvt) begin
			wdTimeoutFlag <= 1'b1; // R7 R15
		end else if (ctrlWrite) begin
			wdTimeoutFlag <= sfrWrData[TOF_BIT]; // R15
		end
	end

	// Counter clear request; a fresh write wins over its completion
	always_ff @(posedge core_clk) begin
		if (chipRst) begin
			wdCountClear <= CTRL_POR_VALUE[CLR_BIT];
		end else if (ctrlWrite && sfrWrData[CLR_BIT]) begin
			wdCountClear <= 1'b1; // R9
		end else if (countClearNow) begin
			wdCountClear <= 1'b0; // R9 R20
		end
	end

	wdtu_prescaler #(
		.DIV_W(PS_W)
	) u_prescaler (
		.core_clk(core_clk),
		.sys_rst(chipRst),
		.clear(countClearNow),
		.enable(counting),
		.sel(wdPrescaleSel),
		.oscTick(lowSpeedTick),
		.outTick(psTick)
	); // R5

	// Time-out counter wraps and keeps going after each interval
	always_ff @(posedge core_clk) begin
		if (chipRst || countClearNow) begin
			wdCount <= '0; // R9
		end else if (psTick) begin
			wdCount <= wdCount + 1'b1; // R4 R14
		end
	end

	// Grace window runs only in reset modes; clearing cancels it
	wdtu_grace_timer #(
		.GRACE(GRACE)
	) u_grace (
		.core_clk(core_clk),
		.sys_rst(chipRst),
		.arm(timeoutEvt && !gpMode),
		.cancel(countClearNow),
		.enable(counting),
		.oscTick(lowSpeedTick),
		.fire(graceFire)
	); // R8

	always_ff @(posedge core_clk) begin
		if (sys_rst || otherRst) begin
			systemReset <= 1'b0;
		end else begin
			systemReset <= graceFire && !systemReset; // R8
		end
	end

	// Wake pulse follows each completed interval
	always_ff @(posedge core_clk) begin
		if (chipRst) begin
			wakeUp <= 1'b0;
		end else begin
			wakeUp <= timeoutEvt; // R17
		end
	end

	// Interrupt request is a level while the flag stands
	always_ff @(posedge core_clk) begin
		if (chipRst) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= wdTimeoutFlag && wdIrqEnable && globalIrqEnable; // R7
		end
	end

	assign ctrlRead = {wdRun, wdCountClear, wdTimeoutFlag, wdLowpowerRun,
		wdResetFlag, wdPrescaleSel};

	// Read data registered; other addresses answer zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sfrRdData <= 8'h00;
		end else if (sfrAddr == WATCHDOG_CONTROL_ADDR) begin
			sfrRdData <= ctrlRead; // R9
		end else begin
			sfrRdData <= 8'h00;
		end
	end

endmodule : wdtu_watchdog_timer_unit

// File: wdtu_watchdog_timer_unit_chk.sv
// Port checker for the watchdog timer unit.
// Assumes bind to the top module; one clock, synchronous reset.
module wdtu_chk
	import wdtu_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Inputs
	input wire logic otherRst,
	input wire logic [7:0] configByte,
	input wire logic lowSpeedTick,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic taOpen,
	input wire logic wdIrqEnable,
	input wire logic globalIrqEnable,
	// Outputs
	input wire logic [7:0] sfrRdData,
	input wire logic irqRequest,
	input wire logic wakeUp,
	input wire logic systemReset
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	property p_irq_gate;
		irqRequest |-> $past(wdIrqEnable) && $past(globalIrqEnable);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq without enables");
	property p_irq_follow;
		wakeUp && wdIrqEnable && globalIrqEnable |=> irqRequest;
	endproperty
	a_irq_follow: assert property (p_irq_follow)
		else $error("irq missing after time-out");
	property p_wake_tick;
		$rose(wakeUp) |-> $past(lowSpeedTick);
	endproperty
	a_wake_tick: assert property (p_wake_tick)
		else $error("wake not on oscillator tick");
	property p_wake_pulse;
		wakeUp |=> !wakeUp;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse)
		else $error("wake longer than one cycle");
	property p_rst_pulse;
		systemReset |=> !systemReset;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse)
		else $error("reset longer than one cycle");
	property p_no_rst_gp;
		configByte[7:4] == MODE_GP && $past(configByte[7:4]) == MODE_GP
			|-> !systemReset;
	endproperty
	a_no_rst_gp: assert property (p_no_rst_gp)
		else $error("reset in general mode");
	// Flag may only fall through a write or some reset
	property p_tof_sticky;
		$fell(sfrRdData[TOF_BIT]) && $past(sfrAddr) == WATCHDOG_CONTROL_ADDR
			|-> ($past(sfrWrEn, 2) && $past(taOpen, 2)) || $past(otherRst, 2)
			|| $past(systemReset, 2) || $past(sys_rst, 2) || $past(sys_rst);
	endproperty
	a_tof_sticky: assert property (p_tof_sticky)
		else $error("flag cleared by hardware");
	property p_rst_flag;
		systemReset ##1 sfrAddr == WATCHDOG_CONTROL_ADDR
			|=> sfrRdData[7:3] == 5'h01;
	endproperty
	a_rst_flag: assert property (p_rst_flag)
		else $error("control wrong after watchdog reset");
	c_wake: cover property (wakeUp);
	c_sysrst: cover property (systemReset);
	c_irq: cover property (irqRequest);
endmodule : wdtu_chk

bind wdtu_watchdog_timer_unit wdtu_chk wdtu_chk_inst (
	.core_clk(core_clk), .sys_rst(sys_rst), .otherRst(otherRst),
	.configByte(configByte), .lowSpeedTick(lowSpeedTick), .sfrAddr(sfrAddr),
	.sfrWrEn(sfrWrEn), .taOpen(taOpen), .wdIrqEnable(wdIrqEnable),
	.globalIrqEnable(globalIrqEnable), .sfrRdData(sfrRdData),
	.irqRequest(irqRequest), .wakeUp(wakeUp), .systemReset(systemReset));

// File: tb_watchdog_timer_unit.sv
// Self-checking bench for the watchdog timer unit.
// Assumes an oscillator tick every fourth core cycle, grace shortened.
module tb_watchdog_timer_unit
	import wdtu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic otherRst = 1'b0;
	logic [7:0] configByte = 8'hFF;
	logic lowSpeedTick = 1'b0;
	logic idleMode = 1'b0;
	logic powerDownMode = 1'b0;
	logic [7:0] sfrAddr = WATCHDOG_CONTROL_ADDR;
	logic sfrWrEn = 1'b0;
	logic [7:0] sfrWrData = 8'h00;
	logic taOpen = 1'b0;
	logic wdIrqEnable = 1'b0;
	logic globalIrqEnable = 1'b0;
	logic [7:0] sfrRdData;
	logic irqRequest;
	logic wakeUp;
	logic systemReset;
	logic [1:0] div = 2'h0;
	int nFail = 0;
	int nTests = 0;
	int n;

	wdtu_watchdog_timer_unit #(.PS_W(8), .GRACE(80)) wdtu_watchdog_timer_unit_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .otherRst(otherRst),
		.configByte(configByte), .lowSpeedTick(lowSpeedTick),
		.idleMode(idleMode), .powerDownMode(powerDownMode),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
		.taOpen(taOpen), .sfrRdData(sfrRdData), .wdIrqEnable(wdIrqEnable),
		.globalIrqEnable(globalIrqEnable), .irqRequest(irqRequest),
		.wakeUp(wakeUp), .systemReset(systemReset));

	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// Fast oscillator keeps the long intervals affordable
	always @(posedge core_clk) begin
		div <= div + 2'h1;
		lowSpeedTick <= (div == 2'h3);
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			nFail++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] d, input logic ta);
		@(posedge core_clk);
		sfrAddr <= WATCHDOG_CONTROL_ADDR;
		sfrWrData <= d;
		taOpen <= ta;
		sfrWrEn <= 1'b1;
		@(posedge core_clk);
		sfrWrEn <= 1'b0;
		taOpen <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		sfrAddr <= a;
		repeat (2) @(posedge core_clk);
		#1 chk("read", e, sfrRdData);
	endtask : rd
	task automatic pulseRst(input bit other);
		@(posedge core_clk);
		if (other) otherRst <= 1'b1;
		else sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		otherRst <= 1'b0;
		sys_rst <= 1'b0;
	endtask : pulseRst
	// Oscillator ticks seen until sig goes high, bounded
	task automatic ticks(ref logic sig, output int c);
		int k;
		c = 0;
		k = 0;
		#1;
		while (sig !== 1'b1 && k < 9000) begin
			c += lowSpeedTick;
			@(posedge core_clk);
			#1;
			k++;
		end
	endtask : ticks
	task automatic gap(input int e);
		ticks(wakeUp, n);
		@(posedge core_clk);
		ticks(wakeUp, n);
		chk("interval", e, n);
	endtask : gap
	task automatic quiet(input int cyc);
		int w;
		w = 0;
		repeat (cyc) begin
			@(posedge core_clk);
			#1 w += wakeUp;
		end
		chk("wakes", 0, w);
	endtask : quiet
	task automatic giveVerdict();
		$display("Checks %0d, mismatches %0d", nTests, nFail);
		if (nFail == 0 && nTests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : giveVerdict

	initial begin
		#900000;
		nFail++;
		giveVerdict();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(WATCHDOG_CONTROL_ADDR, 8'h07);
		rd(8'hAB, 8'h00);
		wr(8'h80, 1'b0);
		rd(WATCHDOG_CONTROL_ADDR, 8'h07);
		wr(8'h80, 1'b1);
		rd(WATCHDOG_CONTROL_ADDR, 8'h80);
		gap(64);
		chk("irq", 0, irqRequest);
		wdIrqEnable <= 1'b1;
		globalIrqEnable <= 1'b1;
		rd(WATCHDOG_CONTROL_ADDR, 8'hA0);
		chk("irq", 1, irqRequest);
		idleMode <= 1'b1;
		wr(8'h81, 1'b1);
		rd(WATCHDOG_CONTROL_ADDR, 8'h81);
		chk("irq", 0, irqRequest);
		quiet(1200);
		wr(8'h91, 1'b1);
		gap(256);
		wr(8'h10, 1'b1);
		quiet(400);
		idleMode <= 1'b0;
		configByte <= 8'h50;
		powerDownMode <= 1'b1;
		pulseRst(1'b0);
		wr(8'h00, 1'b1);
		quiet(400);
		powerDownMode <= 1'b0;
		gap(64);
		wr(8'h40, 1'b1);
		ticks(systemReset, n);
		chk("grace", 1, n >= 144 && n <= 146);
		rd(WATCHDOG_CONTROL_ADDR, 8'h08);
		pulseRst(1'b1);
		rd(WATCHDOG_CONTROL_ADDR, 8'h08);
		configByte <= 8'h00;
		idleMode <= 1'b1;
		pulseRst(1'b0);
		rd(WATCHDOG_CONTROL_ADDR, 8'h07);
		wr(8'h00, 1'b1);
		gap(64);
		giveVerdict();
	end
endmodule : tb_watchdog_timer_unit
